// File: design/eepsq_pkg.sv
// Constants and types shared by the serial EEPROM command sequencer
package eepsq_pkg;
  // Byte and address widths
  localparam int EEPSQ_DATA_W = 8;                // Data byte width
  localparam int EEPSQ_ADDR_W = 9;                // Two blocks of 256 bytes
  localparam int EEPSQ_WORD_W = 8;                // Word address width
  localparam int EEPSQ_PAGE_W = 4;                // Offset bits inside a page
  localparam int EEPSQ_PAGE_BYTES = 16;           // Bytes per page
  localparam int EEPSQ_MEM_BYTES = 512;           // Whole array
  // Slave address fields
  localparam logic [3:0] EEPSQ_TYPE_CODE = 4'ha;  // Device type code
  localparam int EEPSQ_SA_RW = 0;                 // Direction bit, 1 = read
  localparam int EEPSQ_SA_BLK = 1;                // Half block select bit
  localparam int EEPSQ_SA_CSL = 2;                // Compared with low select pin
  localparam int EEPSQ_SA_CSH = 3;                // Compared with high select pin
  localparam int EEPSQ_SA_TYPE = 4;               // Low bit of type code
  // Array contents after reset
  localparam logic [7:0] EEPSQ_ERASED = 8'hff;
  // Internal write cycle timing
  localparam int EEPSQ_CLK_NS = 10;               // 100 MHz clock
  localparam int EEPSQ_TWR_NS = 5000000;          // Write cycle length, 5 ms
  localparam int EEPSQ_TWR_CYC = (EEPSQ_TWR_NS + EEPSQ_CLK_NS - 1) / EEPSQ_CLK_NS;
  // Sequencer states
  typedef enum logic [2:0] {
    EEPSQ_IDLE,
    EEPSQ_ADDR,
    EEPSQ_WORD,
    EEPSQ_WDATA,
    EEPSQ_READ,
    EEPSQ_IGNORE,
    EEPSQ_PROG
  } eepsq_state_t;
endpackage

// File: design/eepsq_top.sv
// Byte-level command sequencer of a 4 Kbit two-wire serial EEPROM
//
// Overview of operation
// RULE1: Array grouped in aligned sixteen-byte pages.
// RULE2: Page write address wraps inside its page.
// RULE3: Page write may start at any offset.
// RULE4: Master sends at most fifteen extra bytes.
// RULE5: Each write byte acked, counter advances.
// RULE6: Excess bytes wrap and overwrite earlier ones.
// RULE7: Stop after write data starts programming.
// RULE8: Busy programming ignores all bus requests.
// RULE9: Master polls with write-direction slave address.
// RULE10: Polling unacked while busy, acked after.
// RULE11: Protected upper half: first data unacked.
// RULE12: Reads start like writes, direction one.
// RULE13: Counter holds last accessed address plus one.
// RULE14: Read address acked, then byte shifted out.
// RULE15: Random read: dummy write, repeated start.
// RULE16: Dummy write word address loads the counter.
// RULE17: Each master ack fetches next byte.
// RULE18: Master nack or stop ends data.
// RULE19: Read counter spans whole array, wraps.
// RULE20: Slave address: type, selects, block, direction.
// RULE21: Select pins compared; low bit picks half.
// RULE22: Word address is eight bits wide.
// RULE23: Block bit one means protected half.
`timescale 1ns/1ps
`default_nettype none
module eepsq_top #(
  parameter int TWR_CYCLES = eepsq_pkg::EEPSQ_TWR_CYC  // Write cycle in clocks
) (
  input  wire logic                             i_clk,
  input  wire logic                             i_rst_b,
  input  wire logic                             i_wp,
  input  wire logic                             i_chip_select_pin_low,
  input  wire logic                             i_chip_select_pin_high,
  input  wire logic                             i_start,
  input  wire logic                             i_stop,
  input  wire logic                             i_rx_valid,
  input  wire logic [eepsq_pkg::EEPSQ_DATA_W-1:0] i_rx_byte,
  output logic                                  o_ack_valid,
  output logic                                  o_ack,
  input  wire logic                             i_mack_valid,
  input  wire logic                             i_mack,
  output logic                                  o_tx_valid,
  output logic [eepsq_pkg::EEPSQ_DATA_W-1:0]    o_tx_byte,
  input  wire logic                             i_tx_ready,
  output logic                                  o_busy
);
  import eepsq_pkg::*;

  localparam int TW = $clog2(TWR_CYCLES + 1);       // Timer width

  // Pin synchronisers
  logic [2:0]              pin_s1_q;                // First stage, read by stage two only
  logic [2:0]              pin_s2_q;                // Stable copies
  logic                    wp_s;                    // Write protect level
  logic                    csl_s;                   // Low select pin level
  logic                    csh_s;                   // High select pin level

  // Sequencer state
  eepsq_state_t            state_q, state_d;        // Command phase
  logic [EEPSQ_ADDR_W-1:0] addr_q, addr_d;          // Address counter
  logic [EEPSQ_DATA_W-1:0] pbuf_q [EEPSQ_PAGE_BYTES];  // Page data latch
  logic [EEPSQ_DATA_W-1:0] pbuf_d [EEPSQ_PAGE_BYTES];
  logic [EEPSQ_PAGE_BYTES-1:0] pmask_q, pmask_d;    // Bytes loaded in page latch
  logic [TW-1:0]           timer_q, timer_d;        // Write cycle countdown
  logic                    rd_req_q, rd_req_d;      // A read byte is wanted
  logic                    ack_v_q, ack_v_d;        // Answer strobe
  logic                    ack_q, ack_d;            // Answer value
  logic                    busy_q, busy_d;          // Programming flag
  logic                    commit;                  // Page latch to array now
  logic                    match;                   // Slave address selects us

  // Array and read buffer
  logic [EEPSQ_DATA_W-1:0] mem_q [EEPSQ_MEM_BYTES]; // Nonvolatile array
  logic                    push;                    // Byte enters buffer
  logic                    pop;                     // Byte leaves buffer
  logic                    flush;                   // Drop buffered bytes
  logic [EEPSQ_DATA_W-1:0] push_data;               // Byte fetched from array
  logic                    v0_q, v0_d;              // Head entry valid
  logic                    v1_q, v1_d;              // Second entry valid
  logic [EEPSQ_DATA_W-1:0] d0_q, d0_d;              // Head entry data
  logic [EEPSQ_DATA_W-1:0] d1_q, d1_d;              // Second entry data

  // Two-flop synchroniser for the strap and protect pins
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
    end else begin
      pin_s1_q <= {i_chip_select_pin_high, i_chip_select_pin_low, i_wp};
      pin_s2_q <= pin_s1_q;
    end
  end

  assign wp_s  = pin_s2_q[0];
  assign csl_s = pin_s2_q[1];
  assign csh_s = pin_s2_q[2];

  // RULE20: slave address decode
  // RULE21: select pins compared here
  assign match = (i_rx_byte[7:EEPSQ_SA_TYPE] == EEPSQ_TYPE_CODE) &&
                 (i_rx_byte[EEPSQ_SA_CSL] == csl_s) &&
                 (i_rx_byte[EEPSQ_SA_CSH] == csh_s);

  // RULE13: fetch byte at counter
  assign push_data = mem_q[addr_q];
  // Fetch only on demand so the counter never runs ahead of the master
  assign push = (state_q == EEPSQ_READ) && rd_req_q && !v1_q;
  assign pop  = v0_q && i_tx_ready;

  // Next-state logic of the sequencer
  always_comb begin
    state_d  = state_q;
    addr_d   = addr_q;
    pbuf_d   = pbuf_q;
    pmask_d  = pmask_q;
    timer_d  = timer_q;
    rd_req_d = rd_req_q;
    ack_v_d  = 1'b0;
    ack_d    = 1'b0;
    commit   = 1'b0;
    flush    = 1'b0;
    // RULE19: read counter wraps whole array
    if (push) begin
      addr_d   = addr_q + 1'b1;
      rd_req_d = 1'b0;
    end
    case (state_q)
      EEPSQ_PROG: begin
        // RULE8: bus ignored while programming
        timer_d = timer_q - 1'b1;
        // RULE10: polling answered with no ack
        if (i_rx_valid) begin
          ack_v_d = 1'b1;
          ack_d   = 1'b0;
        end
        if (timer_q == '0) begin
          commit  = 1'b1;
          pmask_d = '0;
          state_d = EEPSQ_IDLE;
        end
      end
      default: begin
        if (i_stop) begin
          // RULE18: stop ends read data
          flush    = 1'b1;
          rd_req_d = 1'b0;
          // RULE7: stop after data starts programming
          if (state_q == EEPSQ_WDATA && pmask_q != '0) begin
            state_d = EEPSQ_PROG;
            timer_d = TW'(TWR_CYCLES - 1);
          end else begin
            state_d = EEPSQ_IDLE;
          end
        end else if (i_start) begin
          // Repeated start restarts addressing
          flush    = 1'b1;
          rd_req_d = 1'b0;
          state_d  = EEPSQ_ADDR;
        end else if (i_rx_valid) begin
          ack_v_d = 1'b1;
          case (state_q)
            EEPSQ_ADDR: begin
              if (match) begin
                ack_d = 1'b1;
                if (i_rx_byte[EEPSQ_SA_RW]) begin
                  // RULE14: read address acked, fetch byte
                  rd_req_d = 1'b1;
                  state_d  = EEPSQ_READ;
                end else begin
                  // RULE21: block bit picks half
                  addr_d[EEPSQ_ADDR_W-1] = i_rx_byte[EEPSQ_SA_BLK];
                  state_d = EEPSQ_WORD;
                end
              end else begin
                state_d = EEPSQ_IGNORE;
              end
            end
            EEPSQ_WORD: begin
              // RULE16: word address loads counter
              // RULE22: eight-bit word address
              ack_d = 1'b1;
              addr_d[EEPSQ_WORD_W-1:0] = i_rx_byte;
              pmask_d = '0;
              state_d = EEPSQ_WDATA;
            end
            EEPSQ_WDATA: begin
              // RULE11: protected half refuses data
              // RULE23: block bit one is protected
              if (wp_s && addr_q[EEPSQ_ADDR_W-1]) begin
                ack_d   = 1'b0;
                pmask_d = '0;
                state_d = EEPSQ_IGNORE;
              end else begin
                // RULE5: ack byte, bump counter
                // RULE3: any starting offset accepted
                ack_d = 1'b1;
                pbuf_d[addr_q[EEPSQ_PAGE_W-1:0]] = i_rx_byte;
                pmask_d[addr_q[EEPSQ_PAGE_W-1:0]] = 1'b1;
                // RULE2: offset wraps inside page
                // RULE6: later bytes overwrite earlier ones
                addr_d[EEPSQ_PAGE_W-1:0] = addr_q[EEPSQ_PAGE_W-1:0] + 1'b1;
              end
            end
            default: begin
              // Not addressed or sending: no ack
              ack_d = 1'b0;
            end
          endcase
        end else if (state_q == EEPSQ_READ && i_mack_valid) begin
          if (i_mack) begin
            // RULE17: master ack fetches next byte
            rd_req_d = 1'b1;
          end else begin
            // RULE18: master nack ends data
            flush    = 1'b1;
            rd_req_d = 1'b0;
            state_d  = EEPSQ_IGNORE;
          end
        end
      end
    endcase
    busy_d = (state_d == EEPSQ_PROG);
  end

  // Sequencer registers
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q  <= EEPSQ_IDLE;
      addr_q   <= '0;
      pbuf_q   <= '{default: EEPSQ_ERASED};
      pmask_q  <= '0;
      timer_q  <= '0;
      rd_req_q <= 1'b0;
      ack_v_q  <= 1'b0;
      ack_q    <= 1'b0;
      busy_q   <= 1'b0;
    end else begin
      state_q  <= state_d;
      addr_q   <= addr_d;
      pbuf_q   <= pbuf_d;
      pmask_q  <= pmask_d;
      timer_q  <= timer_d;
      rd_req_q <= rd_req_d;
      ack_v_q  <= ack_v_d;
      ack_q    <= ack_d;
      busy_q   <= busy_d;
    end
  end

  // RULE1: array split into aligned pages
  for (genvar g = 0; g < EEPSQ_MEM_BYTES; g++) begin : g_mem
    localparam logic [EEPSQ_ADDR_W-1:0] GA = EEPSQ_ADDR_W'(g);
    // Loaded bytes of the page are written when the cycle ends
    always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        mem_q[g] <= EEPSQ_ERASED;
      end else if (commit && pmask_q[GA[EEPSQ_PAGE_W-1:0]] &&
                   addr_q[EEPSQ_ADDR_W-1:EEPSQ_PAGE_W] ==
                   GA[EEPSQ_ADDR_W-1:EEPSQ_PAGE_W]) begin
        mem_q[g] <= pbuf_q[GA[EEPSQ_PAGE_W-1:0]];
      end
    end
  end

  // Two-entry read buffer, shifting towards the head
  always_comb begin
    v0_d = v0_q;
    v1_d = v1_q;
    d0_d = d0_q;
    d1_d = d1_q;
    if (flush) begin
      // Drop data nobody will take
      v0_d = 1'b0;
      v1_d = 1'b0;
    end else if (pop && push) begin
      // Head leaves, new byte moves straight into the head
      if (v1_q) begin
        d0_d = d1_q;
        d1_d = push_data;
      end else begin
        d0_d = push_data;
      end
    end else if (pop) begin
      // Second entry moves up
      d0_d = d1_q;
      v0_d = v1_q;
      v1_d = 1'b0;
    end else if (push) begin
      // Fill the first free entry
      if (!v0_q) begin
        d0_d = push_data;
        v0_d = 1'b1;
      end else begin
        d1_d = push_data;
        v1_d = 1'b1;
      end
    end
  end

  // Read buffer registers
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      v0_q <= 1'b0;
      v1_q <= 1'b0;
      d0_q <= '0;
      d1_q <= '0;
    end else begin
      v0_q <= v0_d;
      v1_q <= v1_d;
      d0_q <= d0_d;
      d1_q <= d1_d;
    end
  end

  // Outputs straight from flops
  assign o_ack_valid = ack_v_q;
  assign o_ack       = ack_q;
  assign o_tx_valid  = v0_q;
  assign o_tx_byte   = d0_q;
  assign o_busy      = busy_q;
endmodule
`default_nettype wire

// File: sim/eepsq_props.sv
// Port-level checks of the serial EEPROM sequencer
`timescale 1ns/1ps
`default_nettype none
module eepsq_props #(
  parameter int TWR_CYCLES = 20  // Write cycle in clocks
) (
  input wire logic                                 i_clk,
  input wire logic                                 i_rst_b,
  input wire logic                                 i_chip_select_pin_low,
  input wire logic                                 i_chip_select_pin_high,
  input wire logic                                 i_start,
  input wire logic                                 i_stop,
  input wire logic                                 i_rx_valid,
  input wire logic [eepsq_pkg::EEPSQ_DATA_W-1:0]   i_rx_byte,
  input wire logic                                 o_ack_valid,
  input wire logic                                 o_ack,
  input wire logic                                 i_mack_valid,
  input wire logic                                 o_tx_valid,
  input wire logic [eepsq_pkg::EEPSQ_DATA_W-1:0]   o_tx_byte,
  input wire logic                                 i_tx_ready,
  input wire logic                                 o_busy
);
  import eepsq_pkg::*;
  logic [31:0] busy_cnt_q;  // Busy cycles so far
  logic [31:0] busy_cnt_d;  // Next busy count
  // Length of the running write cycle
  always_comb begin
    busy_cnt_d = o_busy ? busy_cnt_q + 32'h1 : 32'h0;
  end
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      busy_cnt_q <= 32'h0;
    end else begin
      busy_cnt_q <= busy_cnt_d;
    end
  end
  default clocking dclk @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);
  // Read address taken and answered
  sequence rd_addr_s;
    i_start ##1 (i_rx_valid && i_rx_byte[7:4] == EEPSQ_TYPE_CODE && i_rx_byte[0])
      ##1 (o_ack_valid && o_ack);
  endsequence
  // Address that names another device
  sequence bad_addr_s;
    i_start ##1 (i_rx_valid && {i_rx_byte[7:4], i_rx_byte[3:2]} !=
      {EEPSQ_TYPE_CODE, i_chip_select_pin_high, i_chip_select_pin_low});
  endsequence
  ack_once_a: assert property (i_rx_valid ##1 !i_rx_valid |-> o_ack_valid ##1 !o_ack_valid)
    else $error("Byte answer missing or long");
  ack_cause_a: assert property (o_ack_valid |-> $past(i_rx_valid))
    else $error("Answer without byte");
  busy_start_a: assert property ($rose(o_busy) |-> $past(i_stop) || $past(i_stop, 2))
    else $error("Write cycle without stop");
  busy_len_a: assert property ($fell(o_busy) |-> busy_cnt_q == TWR_CYCLES)
    else $error("Write cycle length wrong");
  busy_refuse_a: assert property (o_ack_valid && $past(o_busy) |-> !o_ack)
    else $error("Ack while busy");
  tx_first_a: assert property (rd_addr_s |=> o_tx_valid)
    else $error("No byte after read address");
  tx_hold_a: assert property (o_tx_valid && !i_tx_ready && !i_start && !i_stop && !i_mack_valid
    |=> o_tx_valid && $stable(o_tx_byte))
    else $error("Read byte lost");
  stop_quiet_a: assert property (i_stop |-> ##[1:2] !o_tx_valid)
    else $error("Output after stop");
  addr_nack_a: assert property (bad_addr_s |=> o_ack_valid && !o_ack)
    else $error("Foreign address acked");
endmodule
bind eepsq_top eepsq_props #(.TWR_CYCLES(TWR_CYCLES)) u_props (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_chip_select_pin_low(i_chip_select_pin_low),
  .i_chip_select_pin_high(i_chip_select_pin_high), .i_start(i_start), .i_stop(i_stop),
  .i_rx_valid(i_rx_valid), .i_rx_byte(i_rx_byte), .o_ack_valid(o_ack_valid), .o_ack(o_ack),
  .i_mack_valid(i_mack_valid), .o_tx_valid(o_tx_valid), .o_tx_byte(o_tx_byte),
  .i_tx_ready(i_tx_ready), .o_busy(o_busy)
);
`default_nettype wire

// File: sim/eepsq_master.sv
// Byte-level model of the two-wire bus master
`timescale 1ns/1ps
`default_nettype none
module eepsq_master (
  input  wire logic       i_clk,         // Bench clock
  input  wire logic       i_tx_valid,    // Slave byte waiting
  output var  logic       o_start,       // Start or repeated start
  output var  logic       o_stop,        // Stop
  output var  logic       o_rx_valid,    // Byte to slave
  output var  logic [7:0] o_rx_byte,     // Byte value
  output var  logic       o_mack_valid,  // Master answer strobe
  output var  logic       o_mack,        // 1 = more bytes wanted
  output var  logic       o_tx_ready     // Take slave byte
);
  // Idle bus at time zero
  initial begin
    o_start = 1'b0;
    o_stop = 1'b0;
    o_rx_valid = 1'b0;
    o_rx_byte = 8'h00;
    o_mack_valid = 1'b0;
    o_mack = 1'b0;
    o_tx_ready = 1'b0;
  end
  task automatic cond(input logic stp);
    // Idle cycle first, so a stop and the next start never share a step
    @(posedge i_clk);
    #1;
    o_start = !stp;
    o_stop = stp;
    @(posedge i_clk);
    #1;
    o_start = 1'b0;
    o_stop = 1'b0;
  endtask
  task automatic put(input logic [7:0] v);
    o_rx_valid = 1'b1;
    o_rx_byte = v;
    @(posedge i_clk);
    #1;
    o_rx_valid = 1'b0;
    o_rx_byte = ~v;
    @(posedge i_clk);
    #1;
  endtask
  // take byte after a stall, then answer
  task automatic get(input logic mack, input int stall);
    for (int n = 0; n < 8 && !i_tx_valid; n++) begin
      @(posedge i_clk);
      #1;
    end
    repeat (stall) @(posedge i_clk);
    #1;
    o_tx_ready = 1'b1;
    @(posedge i_clk);
    #1;
    o_tx_ready = 1'b0;
    o_mack_valid = 1'b1;
    o_mack = mack;
    @(posedge i_clk);
    #1;
    o_mack_valid = 1'b0;
    o_mack = !mack;
  endtask
endmodule
`default_nettype wire

// File: sim/tb_top.sv
// Self-checking bench for the serial EEPROM sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import eepsq_pkg::*;
  logic       clk = 1'b0;                      // 100 MHz clock
  logic       rst_b = 1'b0;                    // Reset, active low
  logic       wp = 1'b0;                       // Write protect pin
  logic       start, stop, rxv, mackv, mack, txr;  // Master side
  logic       ackv, ack, txv, busy;            // Sequencer outputs
  logic [7:0] rxb, txb, v;                     // Bytes
  logic [8:0] a;                               // Expected address
  logic [7:0] mem [512];                       // Expected array
  logic       ack_q [$];                       // Expected answers
  logic [7:0] tx_q [$];                        // Expected read bytes
  logic [7:0] bad [3];                         // Foreign addresses
  logic       csl, csh;                        // Random strap pin levels
  int         error_cnt = 0;
  int         checks = 0;
  int         cyc = 0;
  int         seed = 80128;
  always #5 clk = ~clk;
  eepsq_top #(.TWR_CYCLES(20)) dut (
    .i_clk(clk), .i_rst_b(rst_b), .i_wp(wp), .i_chip_select_pin_low(csl),
    .i_chip_select_pin_high(csh), .i_start(start), .i_stop(stop), .i_rx_valid(rxv),
    .i_rx_byte(rxb), .o_ack_valid(ackv), .o_ack(ack), .i_mack_valid(mackv), .i_mack(mack),
    .o_tx_valid(txv), .o_tx_byte(txb), .i_tx_ready(txr), .o_busy(busy)
  );
  eepsq_master m (
    .i_clk(clk), .i_tx_valid(txv), .o_start(start), .o_stop(stop), .o_rx_valid(rxv),
    .o_rx_byte(rxb), .o_mack_valid(mackv), .o_mack(mack), .o_tx_ready(txr)
  );
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Slave address for the strapped pins
  function automatic logic [7:0] sa(input logic blk, input logic rd);
    return {EEPSQ_TYPE_CODE, csh, csl, blk, rd};
  endfunction
  task automatic complete_run();
    if (ack_q.size() + tx_q.size() > 0) error_cnt++;
    if (error_cnt == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Oldest note against each answer and each taken byte
  always @(posedge clk) begin
    cyc++;
    if (ackv === 1'b1) chk({7'h0, ack}, ack_q.size() > 0 ? {7'h0, ack_q.pop_front()} : 8'hxx);
    if (txv === 1'b1 && txr === 1'b1) chk(txb, tx_q.size() > 0 ? tx_q.pop_front() : 8'hxx);
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic w(input logic [7:0] b, input logic ok);
    ack_q.push_back(ok);
    m.put(b);
  endtask
  task automatic r(input logic [8:0] ad, input logic more);
    tx_q.push_back(mem[ad]);
    m.get(more, $random(seed) & 3);
  endtask
  task automatic wait_idle();
    for (int n = 0; n < 100 && busy !== 1'b0; n++) @(posedge clk);
    #1;
  endtask
  task automatic wr1(input logic [8:0] ad, input logic ok);
    v = $random(seed);
    m.cond(1'b0);
    w(sa(ad[8], 1'b0), 1'b1);
    w(ad[7:0], 1'b1);
    w(v, ok);
    m.cond(1'b1);
    if (ok) mem[ad] = v;
    repeat (3) @(posedge clk);
    #1;
    if (!ok) chk({7'h0, busy}, 8'h00);
    wait_idle();
  endtask
  task automatic seek(input logic [8:0] ad);
    m.cond(1'b0);
    w(sa(ad[8], 1'b0), 1'b1);
    w(ad[7:0], 1'b1);
    m.cond(1'b0);
    w(sa(ad[8], 1'b1), 1'b1);
  endtask
  initial begin
    for (int i = 0; i < 512; i++) mem[i] = 8'hff;
    // Straps picked at random, foreign addresses built around them
    {csh, csl} = 2'($random(seed));
    bad[0] = {EEPSQ_TYPE_CODE, ~csh, csl, 2'b00};
    bad[1] = {~EEPSQ_TYPE_CODE, csh, csl, 2'b00};
    bad[2] = {EEPSQ_TYPE_CODE, csh, ~csl, 2'b00};
    repeat (16) @(posedge clk);
    #1;
    rst_b = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    // Page write from offset 14, running over the page end once
    m.cond(1'b0);
    w(sa(1'b0, 1'b0), 1'b1);
    w(8'h1e, 1'b1);
    a = 9'h01e;
    for (int i = 0; i < 18; i++) begin
      v = $random(seed);
      mem[a] = v;
      w(v, 1'b1);
      a[3:0] = a[3:0] + 4'h1;
    end
    m.cond(1'b1);
    repeat (3) @(posedge clk);
    #1;
    m.cond(1'b0);
    w(sa(1'b0, 1'b0), 1'b0);
    wait_idle();
    m.cond(1'b0);
    w(sa(1'b0, 1'b0), 1'b1);
    m.cond(1'b1);
    // Sequential read of the whole page
    seek(9'h010);
    a = 9'h010;
    for (int i = 0; i < 16; i++) begin
      r(a, i != 15);
      a++;
    end
    m.cond(1'b1);
    // Abandoned current read still moves the counter
    m.cond(1'b0);
    w(sa(1'b0, 1'b1), 1'b1);
    repeat (4) @(posedge clk);
    #1;
    m.cond(1'b1);
    m.cond(1'b0);
    w(sa(1'b0, 1'b1), 1'b1);
    r(9'h021, 1'b0);
    m.cond(1'b1);
    // Protection covers block 1 only
    wp = 1'b1;
    wr1(9'h000, 1'b1);
    wr1(9'h130, 1'b0);
    wp = 1'b0;
    wr1(9'h1ff, 1'b1);
    seek(9'h1ff);
    r(9'h1ff, 1'b1);
    r(9'h000, 1'b0);
    m.cond(1'b1);
    // Foreign addresses stay unanswered
    foreach (bad[i]) begin
      m.cond(1'b0);
      w(bad[i], 1'b0);
      m.cond(1'b1);
    end
    complete_run();
  end
endmodule
`default_nettype wire
